// ==== common/mseq_pkg.sv ====
// Shared types and constants of the microsequencer and bus routing block
package mseq_pkg;

   // ************************************************
   // Widths and timing
   // ************************************************
   localparam int CMA_W = 10;
   localparam int DW = 16;
   localparam int RF_N = 16;
   localparam int CLK_MHZ = 20;
   localparam int MASTER_MHZ = 15;
   localparam real STEP_NS = 66.6;
   localparam real LONG_PERIOD_NS = 666.6;
   localparam real SHORT_PERIOD_NS = 200.0;
   localparam int LONG_TICKS = int'(LONG_PERIOD_NS / STEP_NS);
   localparam int SHORT_TICKS = int'(SHORT_PERIOD_NS / STEP_NS);
   localparam logic [2:0] SHORTEST_PERIOD_CODE = 3'h7;
   localparam logic [3:0] WSP_REG = 4'hf;
   localparam logic [CMA_W-1:0] RESET_ADDR = 10'h000;

   // ************************************************
   // Field encodings
   // ************************************************
   typedef enum logic [2:0] {
      BRANCH_MUX_SOURCE = 3'h0,
      RETURN_LINK_SOURCE = 3'h1,
      SRC_RSVD2 = 3'h2,
      SRC_RSVD3 = 3'h3,
      SOURCE_OPERAND_ENTRY = 3'h4,
      REENTRY_DECODER_SOURCE = 3'h5,
      S_FIELD_ENTRY_SOURCE = 3'h6,
      D_FIELD_ENTRY_SOURCE = 3'h7
   } mseq_src_t;

   localparam logic [4:0] ALWAYS_BRANCH_ZERO = 5'h00;
   localparam logic [4:0] ALWAYS_BRANCH_ONE = 5'h07;
   localparam logic [4:0] DESTINATION_ENTRY = 5'h01;
   localparam logic [4:0] ALTERNATE_DESTINATION_ENTRY = 5'h02;
   localparam logic [4:0] OPERATION_ENTRY = 5'h03;

   localparam logic OPERAND_BUS_FROM_REGFILE = 1'h0;
   localparam logic OPERAND_BUS_FROM_SWAPPER = 1'h1;

   typedef enum logic [2:0] {
      MODIFIER_BUS_CONSTANT = 3'h0,
      MODIFIER_TWICE_S_FIELD = 3'h1,
      MODIFIER_TWICE_D_FIELD = 3'h2,
      MODIFIER_TWICE_DISPLACEMENT = 3'h3,
      MODIFIER_TWICE_VECTOR = 3'h4,
      MODIFIER_BUS_REGFILE = 3'h5,
      MODIFIER_BUS_STATUS = 3'h6,
      MODIFIER_TWICE_COUNT = 3'h7
   } mseq_bsel_t;

   typedef enum logic [1:0] {
      SWAP_NONE = 2'h0,
      SWAP_ALWAYS_CMD = 2'h1,
      SWAP_ON_ODD_ADDRESS_CMD = 2'h2,
      SWAP_ON_ODD_BYTE_INSTR_CMD = 2'h3
   } mseq_swap_t;

   localparam logic [2:0] FSEL_MDI = 3'h3;
   localparam logic [2:0] FSEL_AOP = 3'h7;

   // ************************************************
   // Carriers
   // ************************************************
   typedef struct packed {
      logic [2:0] cc;
      mseq_src_t ss;
      logic [4:0] test;
      logic [CMA_W-1:0] branch_target_zero;
      logic [DW-1:0] branch_target_one;
      logic [3:0] rf_addr;
      logic a_sel;
      mseq_bsel_t b_sel;
      logic [2:0] f_sel;
      logic regfile_write_bit;
      logic working_reg_load_bit;
      logic ret_load;
      mseq_swap_t swap;
   } mseq_uword_t;

   // Condition lines, in test-code order
   typedef struct packed {
      logic load_irq;
      logic xop_flag;
      logic irq_flag;
      logic general_flag_two;
      logic general_flag_one;
      logic saved_carry_test;
      logic fbus_sign_test;
      logic address_lsb_test;
      logic operand_pos;
      logic pending_irq_test;
      logic parity_odd_test;
      logic arith_overrun_test;
      logic carry_shift_out_test;
      logic same_value_test;
      logic arith_greater_test;
      logic logical_greater_test;
      logic loop_counter_zero_test;
      logic jump_true;
      logic byte_instr;
      logic move_instr_test;
      logic d_field_zero_test;
      logic s_field_zero_test;
   } mseq_cond_t;

   typedef struct packed {
      logic [3:0] s_field;
      logic [3:0] d_field;
      logic [7:0] disp;
      logic [3:0] count;
      logic [3:0] vector;
   } mseq_ir_t;

endpackage : mseq_pkg

// ==== verilog/mseq_core.sv ====
// Microprogram sequencer, register file and operand/modifier bus routing
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module mseq_core
   import mseq_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Debug clock controls
   input wire logic fixed_mode_i,
   input wire logic step_mode_i,
   input wire logic step_i,
   // Current microinstruction
   input wire mseq_uword_t uword_i,
   // Condition lines and instruction register fields
   input wire mseq_cond_t cond_i,
   input wire mseq_ir_t ir_i,
   input wire logic [DW-1:0] status_i,
   // Entry decoder outputs
   input wire logic [CMA_W-1:0] src_entry_i,
   input wire logic [CMA_W-1:0] dst_entry_i,
   input wire logic [CMA_W-1:0] alt_dst_entry_i,
   input wire logic [CMA_W-1:0] op_entry_i,
   // Processor output ports and memory data
   input wire logic [DW-1:0] dop_i,
   input wire logic [DW-1:0] aop_i,
   input wire logic [DW-1:0] mdi_i,
   // Microinstruction clock and sequencing
   output logic uclk_en_o,
   output logic [CMA_W-1:0] cm_addr_o,
   output logic [7:0] cm_drv_o,
   // Datapath buses
   output logic [DW-1:0] fbus_o,
   output logic [DW-1:0] alu_first_input_o,
   output logic [DW-1:0] alu_second_input_o,
   output logic [DW-1:0] wr_data_o,
   output logic wr_load_o
);

   // ************************************************
   // State
   // ************************************************
   typedef struct packed {
      logic [4:0] acc;
      logic [3:0] tcnt;
      logic [CMA_W-1:0] cma;
      logic [7:0] drv;
      logic [CMA_W-1:0] ret;
      logic [RF_N-1:0][DW-1:0] rf;
      logic [DW-1:0] fbus;
      logic [DW-1:0] abus;
      logic [DW-1:0] bbus;
      logic [DW-1:0] wrd;
      logic wrl;
      logic uclk;
   } mseq_state_t;

   mseq_state_t st;
   mseq_state_t next_st;

   // ************************************************
   // Elaboration checks
   // ************************************************
   // Fractional divider: five-bit accumulator, master rate below the clock
   if (MASTER_MHZ < 1 || MASTER_MHZ >= CLK_MHZ || CLK_MHZ > 31) begin : g_bad_ratio
      $error("mseq_core: master tick ratio unusable");
   end
   // Four-bit period counter; code 7 must land on the shortest period
   if (LONG_TICKS > 15 || SHORT_TICKS < 1 || LONG_TICKS - 7 != SHORT_TICKS) begin : g_bad_span
      $error("mseq_core: period range unusable");
   end
   // Field entries keep microword bits above a four-bit IR field
   if (CMA_W < 5 || CMA_W > DW) begin : g_bad_addr
      $error("mseq_core: control address width unusable");
   end
   // Register address and byte swap assume sixteen words of sixteen bits
   if (RF_N != 16 || DW != 16) begin : g_bad_file
      $error("mseq_core: register file shape unusable");
   end

   // ************************************************
   // Combinational terms
   // ************************************************
   logic master_tick;
   logic [5:0] acc_sum;
   logic [3:0] target;
   logic period_end;
   logic step_fire;
   logic [31:0] tests;
   logic cond_true;
   logic [CMA_W-1:0] next_addr;
   logic [DW-1:0] fbus;
   logic [DW-1:0] swapped;
   logic do_swap;
   logic [DW-1:0] rf_rd;
   logic [DW-1:0] abus;
   logic [DW-1:0] bbus;
   logic [7:0] src_onehot;
   logic [RF_N-1:0] rf_we;
   logic clash;

   // Fractional divider gives the 15 MHz master tick rate on average
   always_comb begin
      acc_sum = {1'b0, st.acc} + 6'(MASTER_MHZ);
      master_tick = (acc_sum >= 6'(CLK_MHZ));
   end

   // Period length in master ticks
   // Status tests need code 6 or slower; nothing here enforces it
   always_comb begin
      if (fixed_mode_i) begin
         target = 4'(LONG_TICKS);
      end else begin
         target = 4'(LONG_TICKS) - {1'b0, uword_i.cc};
      end
      period_end = master_tick && (st.tcnt == target - 4'h1) && !step_mode_i;
      step_fire = step_mode_i && step_i;
   end

   // Condition vector indexed by test code; unset entries stay false
   always_comb begin
      tests = 32'h0000_0000;
      tests[0] = 1'b0;
      tests[7] = 1'b1;
      tests[6:1] = {cond_i.loop_counter_zero_test, cond_i.jump_true,
                    cond_i.byte_instr, cond_i.move_instr_test,
                    cond_i.d_field_zero_test, cond_i.s_field_zero_test};
      tests[15:8] = {cond_i.operand_pos, cond_i.pending_irq_test,
                     cond_i.parity_odd_test, cond_i.arith_overrun_test,
                     cond_i.carry_shift_out_test, cond_i.same_value_test,
                     cond_i.arith_greater_test, cond_i.logical_greater_test};
      tests[23:16] = {cond_i.load_irq, cond_i.xop_flag,
                      cond_i.irq_flag, cond_i.general_flag_two,
                      cond_i.general_flag_one, cond_i.saved_carry_test,
                      cond_i.fbus_sign_test, cond_i.address_lsb_test};
      cond_true = tests[uword_i.test];
   end

   // Next control-memory address
   always_comb begin
      next_addr = RESET_ADDR;
      case (uword_i.ss)
         BRANCH_MUX_SOURCE: begin
            if (cond_true) begin
               next_addr = uword_i.branch_target_one[CMA_W-1:0];
            end else begin
               next_addr = uword_i.branch_target_zero;
            end
         end
         RETURN_LINK_SOURCE: begin
            next_addr = st.ret;
         end
         SOURCE_OPERAND_ENTRY: begin
            next_addr = src_entry_i;
         end
         REENTRY_DECODER_SOURCE: begin
            case (uword_i.test)
               DESTINATION_ENTRY: begin
                  next_addr = dst_entry_i;
               end
               ALTERNATE_DESTINATION_ENTRY: begin
                  next_addr = alt_dst_entry_i;
               end
               OPERATION_ENTRY: begin
                  next_addr = op_entry_i;
               end
               default: begin
                  next_addr = RESET_ADDR;
               end
            endcase
         end
         S_FIELD_ENTRY_SOURCE: begin
            next_addr = {uword_i.branch_target_zero[CMA_W-1:4], ir_i.s_field};
         end
         D_FIELD_ENTRY_SOURCE: begin
            next_addr = {uword_i.branch_target_zero[CMA_W-1:4], ir_i.d_field};
         end
         default: begin
            // Reserved sources leave the bus undriven; it reads as zero
            next_addr = RESET_ADDR;
         end
      endcase
   end

   // ************************************************
   // Address bus drivers
   // ************************************************
   // One bus enable per address generator; reserved codes enable none
   for (genvar g = 0; g < 8; g++) begin : g_src_drv
      assign src_onehot[g] = (uword_i.ss == 3'(g))
         && (uword_i.ss != SRC_RSVD2) && (uword_i.ss != SRC_RSVD3);
   end

   // ************************************************
   // Register file
   // ************************************************
   for (genvar r = 0; r < RF_N; r++) begin : g_rf_we
      assign rf_we[r] = uword_i.regfile_write_bit && (uword_i.rf_addr == 4'(r));
   end

   // Written word read onto the operand bus while both loads are set
   assign clash = (uword_i.a_sel == OPERAND_BUS_FROM_REGFILE)
      && uword_i.working_reg_load_bit && uword_i.regfile_write_bit;

   // ************************************************
   // Datapath routing
   // ************************************************
   always_comb begin
      if (uword_i.f_sel == FSEL_MDI) begin
         fbus = mdi_i;
      end else if (uword_i.f_sel == FSEL_AOP) begin
         fbus = aop_i;
      end else begin
         fbus = dop_i;
      end
   end

   // Byte swap ahead of the operand bus
   always_comb begin
      case (uword_i.swap)
         SWAP_ALWAYS_CMD: begin
            do_swap = 1'b1;
         end
         SWAP_ON_ODD_ADDRESS_CMD: begin
            do_swap = cond_i.address_lsb_test;
         end
         SWAP_ON_ODD_BYTE_INSTR_CMD: begin
            do_swap = cond_i.address_lsb_test && cond_i.byte_instr;
         end
         default: begin
            do_swap = 1'b0;
         end
      endcase
      // Upper byte is where byte micro-operations act
      swapped = do_swap ? {fbus[7:0], fbus[15:8]} : fbus;
   end

   always_comb begin
      rf_rd = st.rf[uword_i.rf_addr];
      if (uword_i.a_sel == OPERAND_BUS_FROM_SWAPPER) begin
         abus = swapped;
      end else begin
         abus = rf_rd;
      end
   end

   always_comb begin
      case (uword_i.b_sel)
         MODIFIER_BUS_CONSTANT: begin
            bbus = uword_i.branch_target_one;
         end
         MODIFIER_TWICE_S_FIELD: begin
            bbus = {11'h000, ir_i.s_field, 1'b0};
         end
         MODIFIER_TWICE_D_FIELD: begin
            bbus = {11'h000, ir_i.d_field, 1'b0};
         end
         MODIFIER_TWICE_DISPLACEMENT: begin
            // Displacement is signed
            bbus = {{7{ir_i.disp[7]}}, ir_i.disp, 1'b0};
         end
         MODIFIER_TWICE_VECTOR: begin
            bbus = {11'h000, ir_i.vector, 1'b0};
         end
         MODIFIER_BUS_REGFILE: begin
            bbus = rf_rd;
         end
         MODIFIER_BUS_STATUS: begin
            bbus = status_i;
         end
         default: begin
            bbus = {11'h000, ir_i.count, 1'b0};
         end
      endcase
   end

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      next_st = st;
      next_st.uclk = 1'b0;
      next_st.fbus = fbus;
      next_st.abus = abus;
      next_st.bbus = bbus;
      next_st.wrl = 1'b0;
      if (master_tick) begin
         next_st.acc = 5'(acc_sum - 6'(CLK_MHZ));
      end else begin
         next_st.acc = acc_sum[4:0];
      end
      // A shorter code taken mid-period wraps the counter once
      if (step_mode_i) begin
         next_st.tcnt = 4'h0;
      end else if (period_end) begin
         next_st.tcnt = 4'h0;
      end else if (master_tick) begin
         next_st.tcnt = st.tcnt + 4'h1;
      end
      if (period_end || step_fire) begin
         next_st.uclk = 1'b1;
         next_st.cma = next_addr;
         next_st.drv = src_onehot;
         // Return link loads at the micro clock, usable from the next word on
         if (uword_i.ret_load) begin
            next_st.ret = uword_i.branch_target_one[CMA_W-1:0];
         end
         for (int r = 0; r < RF_N; r++) begin
            if (rf_we[r]) begin
               next_st.rf[r] = fbus;
            end
         end
         next_st.wrl = uword_i.working_reg_load_bit;
         // Direct operand path into the working register
         next_st.wrd = abus;
         // Write path shares the read port, so the working register sees zero
         if (clash) begin
            next_st.wrd = '0;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign uclk_en_o = st.uclk;
   assign cm_addr_o = st.cma;
   assign cm_drv_o = st.drv;
   assign fbus_o = st.fbus;
   assign alu_first_input_o = st.abus;
   assign alu_second_input_o = st.bbus;
   assign wr_data_o = st.wrd;
   assign wr_load_o = st.wrl;

endmodule : mseq_core

`default_nettype wire

// ==== tb/mseq_core_props.sv ====
// Port checker of the microsequencer
`timescale 1ns/10ps
`default_nettype none
module mseq_core_chk
   import mseq_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Inputs
   input wire logic step_mode_i,
   input wire logic step_i,
   input wire mseq_uword_t uword_i,
   input wire mseq_ir_t ir_i,
   input wire logic [DW-1:0] status_i,
   input wire logic [DW-1:0] mdi_i,
   // Outputs
   input wire logic uclk_en_o,
   input wire logic [CMA_W-1:0] cm_addr_o,
   input wire logic [7:0] cm_drv_o,
   input wire logic [DW-1:0] fbus_o,
   input wire logic [DW-1:0] alu_second_input_o,
   input wire logic [DW-1:0] wr_data_o,
   input wire logic wr_load_o
);
   logic [1:0] warm;
   logic ok;
   // $past still sees reset-time values for a few edges
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         warm <= 2'h0;
      end else if (warm != 2'h3) begin
         warm <= warm + 2'h1;
      end
   end
   assign ok = (warm == 2'h3);
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   a_pulse_single: assert property (uclk_en_o |=> !uclk_en_o)
      else $error("micro clock pulse too long");
   a_drv_source: assert property (ok && uclk_en_o |-> cm_drv_o ==
      (($past(uword_i.ss) == SRC_RSVD2 || $past(uword_i.ss) == SRC_RSVD3) ? 8'h00
      : 8'h01 << $past(uword_i.ss))) else $error("wrong address driver");
   a_zero_on_clash: assert property (ok && uclk_en_o && !$past(uword_i.a_sel)
      && $past(uword_i.regfile_write_bit) && $past(uword_i.working_reg_load_bit)
      |-> wr_data_o == 16'h0 && wr_load_o) else $error("clash load not zero");
   a_load_pulse: assert property (wr_load_o |-> uclk_en_o)
      else $error("working load off micro clock");
   a_mdi_fbus: assert property (ok && $past(uword_i.f_sel) == FSEL_MDI
      |-> fbus_o == $past(mdi_i)) else $error("fbus not memory data");
   a_status_modifier: assert property (ok && $past(uword_i.b_sel) == MODIFIER_BUS_STATUS
      |-> alu_second_input_o == $past(status_i)) else $error("modifier not status");
   a_count_modifier: assert property (ok && $past(uword_i.b_sel) == MODIFIER_TWICE_COUNT
      |-> alu_second_input_o == {11'h0, $past(ir_i.count), 1'b0})
      else $error("modifier not twice count");
   a_step_halts: assert property (ok && $past(step_mode_i) && $past(step_mode_i, 2)
      && $past(step_mode_i, 3) && !$past(step_i) && !$past(step_i, 2) |-> !uclk_en_o)
      else $error("micro clock ran in step mode");
   a_branch_one: assert property (ok && uclk_en_o && $past(uword_i.ss) == BRANCH_MUX_SOURCE
      && $past(uword_i.test) == ALWAYS_BRANCH_ONE
      |-> cm_addr_o == $past(uword_i.branch_target_one[CMA_W-1:0]))
      else $error("forced branch missed target one");
   c_load: cover property (uclk_en_o && wr_load_o);
   c_reserved: cover property (uclk_en_o && cm_drv_o == 8'h00);
   c_count: cover property (ok && $past(uword_i.b_sel) == MODIFIER_TWICE_COUNT);
endmodule : mseq_core_chk
bind mseq_core mseq_core_chk chk_u (.clock_i, .rst_i, .step_mode_i, .step_i, .uword_i,
   .ir_i, .status_i, .mdi_i, .uclk_en_o, .cm_addr_o, .cm_drv_o, .fbus_o,
   .alu_second_input_o, .wr_data_o, .wr_load_o);
`default_nettype wire

// ==== tb/mseq_far_model.sv ====
// Far side: entry decoders, ALU output ports, memory data
`timescale 1ns/10ps
`default_nettype none
module mseq_far_model
   import mseq_pkg::*;
(
   // Memory word from the bench
   input wire logic [DW-1:0] mem_word_i,
   // Towards the block
   output logic [CMA_W-1:0] src_entry_o,
   output logic [CMA_W-1:0] dst_entry_o,
   output logic [CMA_W-1:0] alt_dst_entry_o,
   output logic [CMA_W-1:0] op_entry_o,
   output logic [DW-1:0] dop_o,
   output logic [DW-1:0] aop_o,
   output logic [DW-1:0] mdi_o
);
   // Distinct values so a wrong pick shows
   assign src_entry_o = 10'h111;
   assign dst_entry_o = 10'h122;
   assign alt_dst_entry_o = 10'h133;
   assign op_entry_o = 10'h144;
   assign dop_o = 16'h3c3c;
   assign aop_o = 16'hc3c3;
   assign mdi_o = mem_word_i;
endmodule : mseq_far_model
`default_nettype wire

// ==== tb/mseq_core_test.sv ====
// Self-checking bench of the microsequencer
`timescale 1ns/10ps
`default_nettype none
module mseq_core_test
   import mseq_pkg::*;
;
   typedef struct {logic [2:0] ss; logic [4:0] tst; logic [9:0] adr; logic [7:0] drv;} mseq_row_t;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic fixed_mode_i = 1'b0;
   logic step_mode_i = 1'b1;
   logic step_i = 1'b0;
   mseq_uword_t uw = '0;
   mseq_cond_t cond = '0;
   mseq_ir_t ir = '{4'h9, 4'h6, 8'h81, 4'h5, 4'ha};
   logic [DW-1:0] status = 16'h5a5a;
   logic [DW-1:0] mem_word = 16'h0000;
   logic [CMA_W-1:0] src_e, dst_e, alt_e, op_e, cm_addr;
   logic [DW-1:0] dop, aop, mdi, fbus, a_bus, b_bus, wr_data;
   logic [7:0] cm_drv;
   logic uclk, wr_load;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   int n, e;
   mseq_row_t rows [10] = '{'{0, 0, 10'h155, 8'h01}, '{4, 0, 10'h111, 8'h10},
      '{5, 1, 10'h122, 8'h20}, '{5, 2, 10'h133, 8'h20}, '{5, 3, 10'h144, 8'h20},
      '{5, 4, 10'h000, 8'h20}, '{6, 0, 10'h159, 8'h40}, '{7, 0, 10'h156, 8'h80},
      '{2, 0, 10'h000, 8'h00}, '{3, 0, 10'h000, 8'h00}};
   logic [DW-1:0] mexp [8] = '{16'h02aa, 16'h0012, 16'h000c, 16'hff02, 16'h0014, 16'h1234,
      16'h5a5a, 16'h000a};
   logic [2:0] fsel [3] = '{3'h0, FSEL_MDI, FSEL_AOP};
   logic [DW-1:0] fexp [3] = '{16'h3c3c, 16'h1234, 16'hc3c3};

   mseq_far_model far_u (.mem_word_i(mem_word), .src_entry_o(src_e), .dst_entry_o(dst_e),
      .alt_dst_entry_o(alt_e), .op_entry_o(op_e), .dop_o(dop), .aop_o(aop), .mdi_o(mdi));
   mseq_core dut_u (.clock_i(clock_i), .rst_i(rst_i), .fixed_mode_i(fixed_mode_i),
      .step_mode_i(step_mode_i), .step_i(step_i), .uword_i(uw), .cond_i(cond), .ir_i(ir),
      .status_i(status), .src_entry_i(src_e), .dst_entry_i(dst_e), .alt_dst_entry_i(alt_e),
      .op_entry_i(op_e), .dop_i(dop), .aop_i(aop), .mdi_i(mdi), .uclk_en_o(uclk),
      .cm_addr_o(cm_addr), .cm_drv_o(cm_drv), .fbus_o(fbus), .alu_first_input_o(a_bus),
      .alu_second_input_o(b_bus), .wr_data_o(wr_data), .wr_load_o(wr_load));

   initial begin
      forever #25 clock_i = ~clock_i;
   end

   task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wait_n(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask : wait_n

   // One micro clock in step mode, bounded wait for the pulse
   task automatic step();
      @(posedge clock_i);
      step_i <= 1'b1;
      @(posedge clock_i);
      step_i <= 1'b0;
      #1;
      for (int k = 0; k < 6 && uclk !== 1'b1; k++) begin
         wait_n(1);
      end
   endtask : step

   // Cycles spanned by three periods, after two pulses to settle
   task automatic periods(output int cnt);
      cnt = 0;
      for (int k = 0; k < 5 && cnt < 200;) begin
         wait_n(1);
         if (k >= 2) cnt++;
         if (uclk === 1'b1) k++;
      end
   endtask : periods

   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   // Hang guard: the run needs about 700 cycles
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         test_done();
      end
   end

   initial begin
      uw.branch_target_zero = 10'h155;
      uw.branch_target_one = 16'h02aa;
      uw.cc = 3'h6;
      wait_n(10);
      chk("reset addr", 16'h0, cm_addr);
      chk("reset pulse", 16'h0, uclk);
      wait_n(10);
      rst_i <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         uw.ss <= mseq_src_t'(rows[i].ss);
         uw.test <= rows[i].tst;
         step();
         chk("row addr", rows[i].adr, cm_addr);
         chk("row drive", rows[i].drv, cm_drv);
      end
      uw.ss <= BRANCH_MUX_SOURCE;
      for (int c = 0; c < 32; c++) begin
         for (int v = 0; v < 2; v++) begin
            n = (c >= 1 && c <= 6) || (c >= 8 && c <= 23);
            e = (c < 7) ? c - 1 : c - 2;
            if (n) begin
               cond <= mseq_cond_t'(v ? 22'h1 << e : ~(22'h1 << e));
            end else begin
               cond <= mseq_cond_t'(v ? 22'h0 : 22'h3fffff);
            end
            uw.test <= 5'(c);
            step();
            chk("branch", (c == 7 || (n && v)) ? 16'h02aa : 16'h0155, cm_addr);
         end
      end
      cond <= '0;
      uw.ret_load <= 1'b1;
      uw.test <= ALWAYS_BRANCH_ZERO;
      step();
      uw.ret_load <= 1'b0;
      uw.ss <= RETURN_LINK_SOURCE;
      step();
      chk("return addr", 16'h02aa, cm_addr);
      mem_word <= 16'h1234;
      uw.f_sel <= FSEL_MDI;
      uw.rf_addr <= 4'h3;
      uw.regfile_write_bit <= 1'b1;
      wait_n(3);
      step();
      uw.regfile_write_bit <= 1'b0;
      uw.b_sel <= MODIFIER_BUS_REGFILE;
      wait_n(3);
      chk("operand rf", 16'h1234, a_bus);
      chk("modifier rf", 16'h1234, b_bus);
      uw.rf_addr <= WSP_REG;
      wait_n(3);
      chk("other reg", 16'h0, a_bus);
      uw.rf_addr <= 4'h3;
      uw.working_reg_load_bit <= 1'b1;
      step();
      chk("plain load", 16'h1234, wr_data);
      chk("load pulse", 16'h1, wr_load);
      uw.regfile_write_bit <= 1'b1;
      step();
      chk("clash load", 16'h0, wr_data);
      uw.working_reg_load_bit <= 1'b0;
      uw.regfile_write_bit <= 1'b0;
      uw.a_sel <= OPERAND_BUS_FROM_SWAPPER;
      for (int m = 0; m < 16; m++) begin
         uw.swap <= mseq_swap_t'(m >> 2);
         cond.address_lsb_test <= m[1];
         cond.byte_instr <= m[0];
         wait_n(3);
         e = (m >> 2 == 1) || (m >> 2 == 2 && m[1]) || (m >> 2 == 3 && m[1] && m[0]);
         chk("swap", e ? 16'h3412 : 16'h1234, a_bus);
      end
      for (int b = 0; b < 8; b++) begin
         uw.b_sel <= mseq_bsel_t'(b);
         wait_n(3);
         chk("modifier", mexp[b], b_bus);
      end
      for (int f = 0; f < 3; f++) begin
         uw.f_sel <= fsel[f];
         wait_n(3);
         chk("fbus", fexp[f], fbus);
      end
      step_mode_i <= 1'b0;
      for (int c = 0; c < 8; c++) begin
         uw.cc <= 3'(c);
         periods(n);
         chk("period", 16'(4 * (10 - c)), 16'(n));
      end
      fixed_mode_i <= 1'b1;
      periods(n);
      chk("fixed period", 16'h28, 16'(n));
      rst_i <= 1'b1;
      wait_n(2);
      chk("mid reset addr", 16'h0, cm_addr);
      chk("mid reset wr", 16'h0, wr_data);
      uw.a_sel <= OPERAND_BUS_FROM_REGFILE;
      rst_i <= 1'b0;
      wait_n(3);
      chk("file after reset", 16'h0, a_bus);
      test_done();
   end
endmodule : mseq_core_test
`default_nettype wire
